// *** verilog/supply_mgr_status.sv ***
// Status, reset, interrupt, timer and shunt trigger outputs of a four-supply manager.
// Assumes comparator results arrive synchronous to hclk; pins are driven by the pad ring.
//
// Notes on behaviour
// - Longdog output low after longdog expiry.
// - Watchdog output low after watchdog expiry.
// - Mode bit picks shunt_trigger_out or early discharge.
// - Shunt_trigger_out mode: one 20 us high pulse.
// - Each shunt_trigger_out source individually enabled.
// - Early discharge: high until tracking begins.
// - Manual reset low drives resets low.
// - Resets stay low one timeout after release.
// - Manual reset restarts timers after timeout.
// - Clear input low releases interrupt output high.
// - Interrupt blocked while clear held low.
// - Interrupt low when any enabled trigger.
// - Tracking interrupt low on enabled error.
// - Sequence advances only with cards seated.
// - Bypass high masks undervoltage results.
// - Timers held until resets release, then start.
// - Sequence starts on request, seated, no shutdown.
`timescale 1ns/1ps
module supply_mgr_status
   import supply_mgr_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Board and system inputs
   input  wire logic        manual_reset_n,
   input  wire logic        interrupt_clear_n,
   input  wire logic        card_inserted_a_n,
   input  wire logic        card_inserted_b_n,
   input  wire logic        undervoltage_bypass,
   input  wire logic        power_on_request,
   input  wire logic        forced_shutdown_in,
   // Manager comparator results
   input  wire logic [3:0]  uv_raw,
   input  wire logic [3:0]  ov_raw,
   input  wire logic [3:0]  tracking_error,
   input  wire logic [3:0]  overcurrent,
   input  wire logic        tracking_done,
   // Status outputs
   output logic             supply_reset_n_1,
   output logic             supply_reset_n_2,
   output logic             supply_reset_n_3,
   output logic             supply_reset_n_4,
   output logic             interrupt_n,
   output logic             tracking_interrupt_n,
   output logic             watchdog_timeout_n,
   output logic             longdog_timeout_n,
   output logic             shunt_trigger_out
);

   typedef struct packed {
      logic        mr_s1;
      logic        mr_s2;
      logic        clr_s1;
      logic        clr_s2;
      logic        ca_s1;
      logic        ca_s2;
      logic        cb_s1;
      logic        cb_s2;
      logic        byp_s1;
      logic        byp_s2;
      seq_t        seq;
      logic [11:0] hold_cnt;
      logic [23:0] wd_cnt;
      logic [23:0] ld_cnt;
      logic        mode;
      logic        wd_en;
      logic        ld_en;
      logic [3:0]  src_en;
      logic [7:0]  irq_mask;
      logic [3:0]  trk_mask;
      logic [23:0] wd_lim;
      logic [23:0] ld_lim;
      logic [3:0]  src_prev;
      logic [9:0]  pulse_cnt;
      logic        shunt;
      logic        rst_n;
      logic        irq_n;
      logic        trk_n;
      logic        wd_n;
      logic        ld_n;
      logic        a_ph;
      logic        a_wr;
      logic [7:0]  a_addr;
      logic [31:0] rdata;
      logic        rdy;
   } state_t;

   state_t     s;
   state_t     next_s;
   logic [3:0] uv_fault;
   logic       irq_act;
   logic       trk_act;
   logic       start_ok;
   logic [3:0] src_now;
   logic       restart;

   always_comb begin
      next_s = s;
      restart = 1'b0;
      // Input synchronisers
      next_s.mr_s1  = manual_reset_n;
      next_s.mr_s2  = s.mr_s1;
      next_s.clr_s1 = interrupt_clear_n;
      next_s.clr_s2 = s.clr_s1;
      next_s.ca_s1  = card_inserted_a_n;
      next_s.ca_s2  = s.ca_s1;
      next_s.cb_s1  = card_inserted_b_n;
      next_s.cb_s2  = s.cb_s1;
      next_s.byp_s1 = undervoltage_bypass;
      next_s.byp_s2 = s.byp_s1;

      uv_fault = uv_raw & {4{~s.byp_s2}};
      irq_act  = |({ov_raw, uv_fault} & s.irq_mask);
      trk_act  = |(tracking_error & s.trk_mask);
      start_ok = power_on_request && !s.ca_s2 && !s.cb_s2 && !forced_shutdown_in;

      // Bus address and data phases
      next_s.a_ph   = hsel && htrans[1] && hready;
      next_s.a_wr   = hwrite;
      next_s.a_addr = haddr[7:0];
      next_s.rdy    = 1'b1;
      if (s.a_ph && s.a_wr) begin
         unique case (s.a_addr)
            REG_CONTROL: begin
               next_s.mode  = hwdata[CTL_MODE];
               next_s.wd_en = hwdata[CTL_WD_EN];
               next_s.ld_en = hwdata[CTL_LD_EN];
               restart      = hwdata[CTL_RESTART];
            end
            REG_SHUNT_SRC: next_s.src_en = hwdata[3:0];
            REG_IRQ_MASK:  next_s.irq_mask = hwdata[7:0];
            REG_TRK_MASK:  next_s.trk_mask = hwdata[3:0];
            REG_WD_LIMIT:  next_s.wd_lim = hwdata[23:0];
            REG_LD_LIMIT:  next_s.ld_lim = hwdata[23:0];
            default: ;
         endcase
      end

      // Power-on sequence
      unique case (s.seq)
         SEQ_IDLE:
            if (start_ok) begin
               next_s.seq = SEQ_TRACK;
            end
         SEQ_TRACK:
            if (tracking_done) begin
               next_s.seq = SEQ_HOLD;
               next_s.hold_cnt = 12'h000;
            end
         SEQ_HOLD:
            if (!s.mr_s2 || (|uv_fault)) begin
               next_s.hold_cnt = 12'h000;
            end else if (s.hold_cnt == 12'(RESET_TIMEOUT_CYC - 1)) begin
               next_s.seq = SEQ_RUN;
            end else begin
               next_s.hold_cnt = s.hold_cnt + 12'h001;
            end
         SEQ_RUN:
            if (!s.mr_s2 || (|uv_fault)) begin
               next_s.seq = SEQ_HOLD;
               next_s.hold_cnt = 12'h000;
            end
      endcase
      if (!start_ok) begin
         next_s.seq = SEQ_IDLE;
      end
      next_s.rst_n = (next_s.seq == SEQ_RUN);

      // Watchdog and longdog timers
      if (next_s.seq != SEQ_RUN) begin
         next_s.wd_cnt = 24'h000000;
         next_s.ld_cnt = 24'h000000;
         next_s.wd_n   = 1'b1;
         next_s.ld_n   = 1'b1;
      end else begin
         next_s.wd_n = !(s.wd_en && s.wd_cnt == s.wd_lim && s.wd_n) && (s.wd_n || restart);
         next_s.ld_n = !(s.ld_en && s.ld_cnt == s.ld_lim && s.ld_n) && (s.ld_n || restart);
         if (restart) begin
            next_s.wd_cnt = 24'h000000;
            next_s.ld_cnt = 24'h000000;
         end else begin
            if (s.wd_en && s.wd_cnt != s.wd_lim) begin
               next_s.wd_cnt = s.wd_cnt + 24'h000001;
            end
            if (s.ld_en && s.ld_cnt != s.ld_lim) begin
               next_s.ld_cnt = s.ld_cnt + 24'h000001;
            end
         end
      end

      // Interrupt outputs
      next_s.irq_n = !(irq_act && s.clr_s2);
      next_s.trk_n = !trk_act;

      // Shunt trigger
      src_now = {(|overcurrent), forced_shutdown_in, trk_act, irq_act};
      next_s.src_prev = src_now;
      if (s.pulse_cnt != 10'h000) begin
         next_s.pulse_cnt = s.pulse_cnt - 10'h001;
      end else if (!s.mode && (|(src_now & ~s.src_prev & s.src_en))) begin
         next_s.pulse_cnt = 10'(SHUNT_PULSE_CYC);
      end
      if (next_s.mode) begin
         next_s.shunt = (next_s.seq == SEQ_IDLE);
      end else begin
         next_s.shunt = (next_s.pulse_cnt != 10'h000);
      end

      // Read data reflects any write of the same cycle
      next_s.rdata = 32'h00000000;
      if (next_s.a_ph && !next_s.a_wr) begin
         unique case (next_s.a_addr)
            REG_CONTROL:   next_s.rdata = {29'h0, next_s.ld_en, next_s.wd_en, next_s.mode};
            REG_SHUNT_SRC: next_s.rdata = {28'h0, next_s.src_en};
            REG_IRQ_MASK:  next_s.rdata = {24'h0, next_s.irq_mask};
            REG_TRK_MASK:  next_s.rdata = {28'h0, next_s.trk_mask};
            REG_WD_LIMIT:  next_s.rdata = {8'h00, next_s.wd_lim};
            REG_LD_LIMIT:  next_s.rdata = {8'h00, next_s.ld_lim};
            REG_STATUS:    next_s.rdata = {19'h0, s.byp_s2, s.cb_s2, s.ca_s2, s.clr_s2, s.mr_s2,
                                           s.shunt, s.ld_n, s.wd_n, s.trk_n, s.irq_n, s.rst_n, s.seq};
            default:       next_s.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '{mr_s1: 1'b1, mr_s2: 1'b1, clr_s1: 1'b1, clr_s2: 1'b1,
                ca_s1: 1'b1, ca_s2: 1'b1, cb_s1: 1'b1, cb_s2: 1'b1,
                byp_s1: 1'b1, byp_s2: 1'b1, seq: SEQ_IDLE, hold_cnt: 12'h000,
                wd_cnt: 24'h000000, ld_cnt: 24'h000000, mode: MODE_RST,
                wd_en: WD_EN_RST, ld_en: LD_EN_RST, src_en: SHUNT_SRC_RST,
                irq_mask: IRQ_MASK_RST, trk_mask: TRK_MASK_RST,
                wd_lim: WD_LIMIT_RST, ld_lim: LD_LIMIT_RST, src_prev: 4'h0,
                pulse_cnt: 10'h000, shunt: 1'b0, rst_n: 1'b0, irq_n: 1'b1,
                trk_n: 1'b1, wd_n: 1'b1, ld_n: 1'b1, a_ph: 1'b0, a_wr: 1'b0,
                a_addr: 8'h00, rdata: 32'h00000000, rdy: 1'b1};
      end else begin
         s <= next_s;
      end
   end

   assign hreadyout            = s.rdy;
   assign hrdata               = s.rdata;
   assign hresp                = 1'b0;
   assign supply_reset_n_1     = s.rst_n;
   assign supply_reset_n_2     = s.rst_n;
   assign supply_reset_n_3     = s.rst_n;
   assign supply_reset_n_4     = s.rst_n;
   assign interrupt_n          = s.irq_n;
   assign tracking_interrupt_n = s.trk_n;
   assign watchdog_timeout_n   = s.wd_n;
   assign longdog_timeout_n    = s.ld_n;
   assign shunt_trigger_out    = s.shunt;

   // Checks
   localparam int PULSE_LAST = SHUNT_PULSE_CYC - 1;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_mr_low;
      !s.mr_s2 |=> !supply_reset_n_1 && !supply_reset_n_4;
   endproperty
   a_mr_low: assert property (p_mr_low) else $error("reset released during manual reset");

   property p_hold;
      $rose(supply_reset_n_1) |-> $past(s.hold_cnt) == 12'(RESET_TIMEOUT_CYC - 1) && $past(s.mr_s2);
   endproperty
   a_hold: assert property (p_hold) else $error("reset released before timeout");

   property p_clr;
      !s.clr_s2 |=> interrupt_n;
   endproperty
   a_clr: assert property (p_clr) else $error("interrupt active while clear low");

   property p_irq;
      s.clr_s2 && irq_act |=> !interrupt_n;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing on trigger");

   property p_trk;
      trk_act |=> !tracking_interrupt_n;
   endproperty
   a_trk: assert property (p_trk) else $error("tracking interrupt missing");

   property p_pulse;
      !s.mode && $rose(shunt_trigger_out) |-> ##[PULSE_LAST:PULSE_LAST] shunt_trigger_out ##1 !shunt_trigger_out;
   endproperty
   a_pulse: assert property (p_pulse) else $error("shunt_trigger_out pulse length wrong");

   property p_evd;
      s.mode && $past(s.mode) |-> shunt_trigger_out == (s.seq == SEQ_IDLE);
   endproperty
   a_evd: assert property (p_evd) else $error("early discharge level wrong");

   property p_timers;
      !supply_reset_n_1 |-> s.wd_cnt == 24'h000000 && s.ld_cnt == 24'h000000 && watchdog_timeout_n;
   endproperty
   a_timers: assert property (p_timers) else $error("timer active during reset");

   property p_start;
      s.seq == SEQ_IDLE ##1 s.seq == SEQ_TRACK |-> $past(start_ok);
   endproperty
   a_start: assert property (p_start) else $error("sequence started without enable");

   property p_cov_run;
      s.seq == SEQ_HOLD ##1 s.seq == SEQ_RUN;
   endproperty
   c_cov_run: cover property (p_cov_run);

   property p_cov_pulse;
      $fell(shunt_trigger_out) && !s.mode;
   endproperty
   c_cov_pulse: cover property (p_cov_pulse);

   property p_cov_wdo;
      $fell(watchdog_timeout_n);
   endproperty
   c_cov_wdo: cover property (p_cov_wdo);

endmodule

// *** verilog/supply_mgr_pkg.sv ***
// Constants for the supply manager status output block.
// Assumes a single 25 MHz AHB-Lite clock domain.
package supply_mgr_pkg;

   // Clock and times
   localparam int CLK_PERIOD_NS       = 40;
   localparam int RESET_TIMEOUT_US    = 100;
   localparam int SHUNT_PULSE_US      = 20;
   localparam int RESET_TIMEOUT_CYC   = (RESET_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SHUNT_PULSE_CYC     = (SHUNT_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Register byte offsets
   localparam logic [7:0] REG_CONTROL   = 8'h00;
   localparam logic [7:0] REG_SHUNT_SRC = 8'h04;
   localparam logic [7:0] REG_IRQ_MASK  = 8'h08;
   localparam logic [7:0] REG_TRK_MASK  = 8'h0C;
   localparam logic [7:0] REG_WD_LIMIT  = 8'h10;
   localparam logic [7:0] REG_LD_LIMIT  = 8'h14;
   localparam logic [7:0] REG_STATUS    = 8'h18;

   // Control fields
   localparam int CTL_MODE    = 0;
   localparam int CTL_WD_EN   = 1;
   localparam int CTL_LD_EN   = 2;
   localparam int CTL_RESTART = 3;

   // Shunt trigger source bits
   localparam int SRC_IRQ   = 0;
   localparam int SRC_TRK   = 1;
   localparam int SRC_FSD   = 2;
   localparam int SRC_OCUR  = 3;

   // Reset values
   localparam logic        MODE_RST      = 1'b0;
   localparam logic        WD_EN_RST     = 1'b1;
   localparam logic        LD_EN_RST     = 1'b1;
   localparam logic [3:0]  SHUNT_SRC_RST = 4'h0;
   localparam logic [7:0]  IRQ_MASK_RST  = 8'hFF;
   localparam logic [3:0]  TRK_MASK_RST  = 4'hF;
   localparam logic [23:0] WD_LIMIT_RST  = 24'h0F4240;
   localparam logic [23:0] LD_LIMIT_RST  = 24'h3D0900;

   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'b00,
      SEQ_TRACK = 2'b01,
      SEQ_HOLD  = 2'b10,
      SEQ_RUN   = 2'b11
   } seq_t;

endpackage

// *** verification/board_model.sv ***
// Board-side model: supervisory pins driven toward the supply manager.
// Assumes the bench sets requested levels just after a rising hclk edge.
`timescale 1ns/1ps
module board_model (
   // Clock
   input  wire logic       hclk,
   // Requested levels: mr, clr, card a, card b, bypass, request, shutdown
   input  wire logic [6:0] req,
   // Pins
   output logic            manual_reset_n,
   output logic            interrupt_clear_n,
   output logic            card_inserted_a_n,
   output logic            card_inserted_b_n,
   output logic            undervoltage_bypass,
   output logic            power_on_request,
   output logic            forced_shutdown_in
);
   always_ff @(posedge hclk) begin
      manual_reset_n      <= req[0];
      interrupt_clear_n   <= req[1];
      card_inserted_a_n   <= req[2];
      card_inserted_b_n   <= req[3];
      undervoltage_bypass <= req[4];
      power_on_request    <= req[5];
      forced_shutdown_in  <= req[6];
   end
endmodule

// *** verification/tb_supply_manager_status_outputs.sv ***
// Self-checking bench for the supply manager status outputs.
// Assumes one AHB-Lite slave with fewer than 50 wait cycles per transfer and a 25 MHz clock.
`timescale 1ns/1ps
module tb_supply_manager_status_outputs;
   import supply_mgr_pkg::*;
   typedef struct { bit pin; string nm; logic [31:0] m; logic [31:0] v; } note_t;
   localparam logic [8:0] P_SH = 9'h001, P_LD = 9'h002, P_WD = 9'h004, P_TK = 9'h008;
   localparam logic [8:0] P_IQ = 9'h010, P_RS = 9'h1E0;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hready_s, tdone;
   logic [31:0] haddr, hwdata, hrdata, hrdata_s, obs_val, rnd;
   logic [1:0]  htrans;
   logic [6:0]  req;
   logic [3:0]  uv, ov, trk, oc;
   logic        mr_n, clr_n, ca_n, cb_n, byp, por, fsd;
   logic        r1, r2, r3, r4, irq_n, trk_n, wd_n, ld_n, shunt;
   wire  [8:0]  pins = {r1, r2, r3, r4, irq_n, trk_n, wd_n, ld_n, shunt};
   int          error_cnt = 0;
   int          tests_run = 0;
   note_t       q[$];
   note_t       nt;
   event        obs;
   always #20 hclk = ~hclk;
   always @(negedge hclk) begin
      hready_s <= hreadyout;
      hrdata_s <= hrdata;
   end
   board_model board_model_i (.hclk(hclk), .req(req), .manual_reset_n(mr_n), .interrupt_clear_n(clr_n),
      .card_inserted_a_n(ca_n), .card_inserted_b_n(cb_n), .undervoltage_bypass(byp),
      .power_on_request(por), .forced_shutdown_in(fsd));
   supply_mgr_status supply_mgr_status_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .manual_reset_n(mr_n),
      .interrupt_clear_n(clr_n), .card_inserted_a_n(ca_n), .card_inserted_b_n(cb_n),
      .undervoltage_bypass(byp), .power_on_request(por), .forced_shutdown_in(fsd), .uv_raw(uv),
      .ov_raw(ov), .tracking_error(trk), .overcurrent(oc), .tracking_done(tdone),
      .supply_reset_n_1(r1), .supply_reset_n_2(r2), .supply_reset_n_3(r3), .supply_reset_n_4(r4),
      .interrupt_n(irq_n), .tracking_interrupt_n(trk_n), .watchdog_timeout_n(wd_n),
      .longdog_timeout_n(ld_n), .shunt_trigger_out(shunt));
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cmp_pin(string nm, logic [8:0] m, logic [8:0] v);
      if ((pins & m) !== v) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, v, pins & m);
         error_cnt++;
      end
   endtask
   task automatic cmp_val(string nm, logic [31:0] v);
      if (obs_val !== v) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, v, obs_val);
         error_cnt++;
      end
   endtask
   always @(obs) begin
      nt = q.pop_front();
      tests_run++;
      if (nt.pin) cmp_pin(nt.nm, nt.m[8:0], nt.v[8:0]);
      else cmp_val(nt.nm, nt.v);
   end
   task automatic exp_pin(logic [8:0] m, logic [8:0] v);
      @(negedge hclk);
      q.push_back('{1'b1, "pins", {23'h0, m}, {23'h0, v}});
      ->obs;
   endtask
   task automatic exp_val(string nm, logic [31:0] v, logic [31:0] s);
      @(negedge hclk);
      obs_val = s;
      q.push_back('{1'b0, nm, 32'hFFFFFFFF, v});
      ->obs;
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge hclk);
   endtask
   task automatic wt(logic [8:0] m, logic [8:0] v, int lim);
      int n;
      n = 0;
      while ((pins & m) !== v && n < lim) begin
         @(negedge hclk);
         n++;
      end
      if (n >= lim) begin
         $display("CHECK FAILED wait pins expected %h seen %h", v, pins & m);
         error_cnt++;
         test_done();
      end
   endtask
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hready_s !== 1'b1 && n < 50) begin
         @(posedge hclk);
         n++;
      end
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hready_s !== 1'b1 && n < 50) begin
         @(posedge hclk);
         n++;
      end
      r = hrdata_s;
      if (n >= 50) begin
         $display("CHECK FAILED bus ready expected 1 seen %b", hready_s);
         error_cnt++;
         test_done();
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      exp_val(nm, e, r);
   endtask
   task automatic pulse();
      int n;
      wt(P_SH, P_SH, 6);
      n = 0;
      while (shunt === 1'b1 && n < 1000) begin
         @(negedge hclk);
         n++;
      end
      exp_val("pulse", SHUNT_PULSE_CYC, n);
   endtask
   initial begin
      {hclk, hresetn, hsel, hwrite, tdone} = 5'h0;
      {haddr, hwdata, htrans} = '0;
      {uv, ov, trk, oc} = 16'h0;
      req = 7'h0F;
      void'($urandom(63925));
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      exp_pin(9'h1FF, P_IQ | P_TK | P_WD | P_LD);
      rd(REG_CONTROL, {29'h0, LD_EN_RST, WD_EN_RST, MODE_RST}, "control");
      rd(REG_SHUNT_SRC, {28'h0, SHUNT_SRC_RST}, "shunt_src");
      rd(REG_IRQ_MASK, {24'h0, IRQ_MASK_RST}, "irq_mask");
      rd(REG_TRK_MASK, {28'h0, TRK_MASK_RST}, "trk_mask");
      rd(REG_WD_LIMIT, {8'h0, WD_LIMIT_RST}, "wd_limit");
      rd(REG_LD_LIMIT, {8'h0, LD_LIMIT_RST}, "ld_limit");
      rd(REG_STATUS, 32'h00000F78, "status");
      wr(8'h1C, 32'hFFFFFFFF);
      rd(8'h1C, 32'h0, "unmapped");
      exp_val("hresp", 32'h0, {31'h0, hresp});
      rnd = $urandom;
      wr(REG_SHUNT_SRC, rnd);
      rd(REG_SHUNT_SRC, {28'h0, rnd[3:0]}, "shunt_src");
      wr(REG_SHUNT_SRC, 32'h0);
      wr(REG_CONTROL, 32'h7);
      wr(REG_WD_LIMIT, 32'h28);
      wr(REG_LD_LIMIT, 32'h50);
      wt(P_SH, P_SH, 6);
      exp_pin(P_SH, P_SH);
      @(posedge hclk) req <= 7'h2B;
      cyc(20);
      exp_pin(P_SH | P_RS, P_SH);
      @(posedge hclk) req <= 7'h23;
      wt(P_SH, 9'h0, 10);
      exp_pin(P_SH, 9'h0);
      @(posedge hclk) tdone <= 1'b1;
      cyc(2400);
      exp_pin(P_RS, 9'h0);
      wt(P_RS, P_RS, 300);
      cyc(20);
      exp_pin(P_WD | P_LD, P_WD | P_LD);
      wt(P_WD, 9'h0, 60);
      exp_pin(P_WD | P_LD, P_LD);
      wt(P_LD, 9'h0, 100);
      exp_pin(P_LD, 9'h0);
      @(posedge hclk) req <= 7'h22;
      wt(P_RS, 9'h0, 6);
      cyc(100);
      exp_pin(P_RS, 9'h0);
      @(posedge hclk) req <= 7'h23;
      cyc(1000);
      @(posedge hclk) req <= 7'h22;
      cyc(10);
      @(posedge hclk) req <= 7'h23;
      cyc(2000);
      exp_pin(P_RS, 9'h0);
      cyc(400);
      exp_pin(P_RS, 9'h0);
      wt(P_RS, P_RS, 200);
      exp_pin(P_WD | P_LD, P_WD | P_LD);
      wt(P_WD, 9'h0, 60);
      wr(REG_CONTROL, 32'hF);
      exp_pin(P_WD | P_LD, P_WD | P_LD);
      wr(REG_CONTROL, 32'h0);
      @(posedge hclk) ov <= 4'h2;
      wt(P_IQ, 9'h0, 6);
      exp_pin(P_IQ, 9'h0);
      @(posedge hclk) req <= 7'h21;
      wt(P_IQ, P_IQ, 6);
      exp_pin(P_IQ, P_IQ);
      cyc(20);
      exp_pin(P_IQ, P_IQ);
      @(posedge hclk) req <= 7'h23;
      wt(P_IQ, 9'h0, 6);
      exp_pin(P_IQ, 9'h0);
      @(posedge hclk) ov <= 4'h0;
      req <= 7'h21;
      cyc(5);
      @(posedge hclk) req <= 7'h23;
      cyc(5);
      exp_pin(P_IQ, P_IQ);
      wr(REG_IRQ_MASK, 32'h0);
      @(posedge hclk) ov <= 4'hF;
      cyc(10);
      exp_pin(P_IQ, P_IQ);
      @(posedge hclk) ov <= 4'h0;
      wr(REG_IRQ_MASK, 32'hFF);
      @(posedge hclk) req <= 7'h33;
      cyc(5);
      @(posedge hclk) uv <= 4'hF;
      cyc(20);
      exp_pin(P_IQ | P_RS, P_IQ | P_RS);
      @(posedge hclk) req <= 7'h23;
      wt(P_IQ | P_RS, 9'h0, 8);
      exp_pin(P_IQ | P_RS, 9'h0);
      @(posedge hclk) uv <= 4'h0;
      cyc(3);
      wr(REG_TRK_MASK, 32'hB);
      @(posedge hclk) trk <= 4'h4;
      cyc(10);
      exp_pin(P_TK, P_TK);
      wr(REG_TRK_MASK, 32'hF);
      wt(P_TK, 9'h0, 6);
      exp_pin(P_TK | P_SH, 9'h0);
      @(posedge hclk) trk <= 4'h0;
      @(posedge hclk) req <= 7'h63;
      cyc(20);
      exp_pin(P_SH, 9'h0);
      @(posedge hclk) req <= 7'h23;
      for (int i = 0; i < 4; i++) begin
         wr(REG_SHUNT_SRC, 32'h1 << i);
         @(posedge hclk);
         case (i)
            0: ov <= 4'h1;
            1: trk <= 4'h2;
            2: req <= 7'h63;
            default: oc <= 4'h8;
         endcase
         pulse();
         @(posedge hclk) {ov, trk, oc} <= 12'h0;
         req <= 7'h21;
         cyc(5);
         @(posedge hclk) req <= 7'h23;
         cyc(5);
      end
      test_done();
   end
endmodule
